/* ext_mem_pkg.sv */
package ext_mem_pkg;
    // bus geometry
    localparam int ADDR_WIDTH = 15;
    localparam int DATA_WIDTH = 16;
    // reset values
    localparam logic [14:0] ADDR_RESET = 15'h0000;
    localparam logic BANK_RESET = 1'h0;
    // bank select encoding
    localparam logic BANK_X = 1'h0;
    localparam logic BANK_Y = 1'h1;
    // strobe timing
    localparam int STROBE_NS = 50;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // controller states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STROBE,
        ST_DONE,
        ST_GRANTED
    } state_type;
endpackage : ext_mem_pkg

/* ext_mem_count.sv */
`timescale 1ns/1ps
// ************************************************
// strobe length counter
// ************************************************
module ext_mem_count #(
    parameter int WIDTH = 4
) (
    // clock and control
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // status
    output logic expired
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // next count
    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_value;
        end else if (count_q != '0) begin
            count_d = count_q - 1'b1;
        end
    end

    // count register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= '0;
        end else if (clk_en) begin
            count_q <= count_d;
        end
    end

    assign expired = (count_q == '0);
endmodule : ext_mem_count

/* ext_data_mem_port.sv */
`timescale 1ns/1ps
module ext_data_mem_port #(
    parameter int STROBE_LEN = ext_mem_pkg::STROBE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // core request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_bank_y,
    input wire logic [ext_mem_pkg::ADDR_WIDTH-1:0] req_addr,
    input wire logic [ext_mem_pkg::DATA_WIDTH-1:0] req_wdata,
    output logic rd_valid,
    output logic [ext_mem_pkg::DATA_WIDTH-1:0] rd_data,
    // memory pins
    output logic bank_sel_o,
    output logic bank_sel_oe,
    output logic [ext_mem_pkg::ADDR_WIDTH-1:0] ext_word_address_o,
    output logic ext_word_address_oe,
    input wire logic [ext_mem_pkg::DATA_WIDTH-1:0] ext_data_bus_i,
    output logic [ext_mem_pkg::DATA_WIDTH-1:0] ext_data_bus_o,
    output logic ext_data_bus_oe,
    output logic ext_read_strobe_n_o,
    output logic ext_write_strobe_n_o,
    output logic strobe_oe,
    // bus hold pins
    input wire logic bus_hold_request_n,
    output logic bus_hold_grant_n,
    output logic bus_owned_strobe_n
);
    // ************************************************
    // state
    // ************************************************
    ext_mem_pkg::state_type state_q, state_d;
    logic [ext_mem_pkg::ADDR_WIDTH-1:0] addr_q, addr_d;
    logic [ext_mem_pkg::DATA_WIDTH-1:0] wdata_q, wdata_d;
    logic [ext_mem_pkg::DATA_WIDTH-1:0] rdata_q, rdata_d;
    logic bank_q, bank_d;
    logic write_q, write_d;
    logic rd_valid_q, rd_valid_d;
    logic cnt_load;
    logic cnt_expired;

    // strobe width counter
    ext_mem_count #(
        .WIDTH(4)
    ) ext_mem_count_i (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .load(cnt_load),
        .load_value(4'(STROBE_LEN - 1)),
        .expired(cnt_expired)
    );

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        bank_d = bank_q;
        write_d = write_q;
        rd_valid_d = 1'b0;
        cnt_load = 1'b0;
        case (state_q)
            ext_mem_pkg::ST_IDLE: begin
                if (!bus_hold_request_n) begin
                    state_d = ext_mem_pkg::ST_GRANTED;
                end else if (req_valid) begin
                    addr_d = req_addr;
                    bank_d = req_bank_y ? ext_mem_pkg::BANK_Y : ext_mem_pkg::BANK_X;
                    write_d = req_write;
                    wdata_d = req_wdata;
                    cnt_load = 1'b1;
                    state_d = ext_mem_pkg::ST_STROBE;
                end
            end
            ext_mem_pkg::ST_STROBE: begin
                // hold is not honoured mid access
                if (cnt_expired) begin
                    if (!write_q) begin
                        rdata_d = ext_data_bus_i;
                        rd_valid_d = 1'b1;
                    end
                    state_d = ext_mem_pkg::ST_DONE;
                end
            end
            ext_mem_pkg::ST_DONE: begin
                state_d = ext_mem_pkg::ST_IDLE; // address kept
            end
            ext_mem_pkg::ST_GRANTED: begin
                if (bus_hold_request_n) begin
                    state_d = ext_mem_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = ext_mem_pkg::ST_IDLE;
            end
        endcase
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ext_mem_pkg::ST_IDLE;
            addr_q <= ext_mem_pkg::ADDR_RESET;
            bank_q <= ext_mem_pkg::BANK_RESET;
            wdata_q <= '0;
            rdata_q <= '0;
            write_q <= 1'b0;
            rd_valid_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            addr_q <= addr_d;
            bank_q <= bank_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            write_q <= write_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // ************************************************
    // pin drive
    // ************************************************
    logic granted;
    logic strobing;

    // state decode
    assign granted = (state_q == ext_mem_pkg::ST_GRANTED);
    assign strobing = (state_q == ext_mem_pkg::ST_STROBE);

    // core side handshake and read data
    assign req_ready = (state_q == ext_mem_pkg::ST_IDLE) && bus_hold_request_n;
    assign rd_valid = rd_valid_q;
    assign rd_data = rdata_q;

    // address and bank, driven unless granted
    assign bank_sel_o = bank_q;
    assign ext_word_address_o = addr_q;
    assign bank_sel_oe = !granted;
    assign ext_word_address_oe = !granted;

    // strobes, one of them low per access
    assign strobe_oe = !granted;
    assign ext_read_strobe_n_o = !(strobing && !write_q);
    assign ext_write_strobe_n_o = !(strobing && write_q);

    // data bus, driven only inside a write strobe
    assign ext_data_bus_o = wdata_q;
    assign ext_data_bus_oe = strobing && write_q;

    // hold handshake and own bus strobe
    assign bus_owned_strobe_n = !strobing;
    assign bus_hold_grant_n = !granted;

    // ************************************************
    // check helpers
    // ************************************************
    logic [4:0] strobe_run_q, strobe_run_d;

    // cycles the current strobe has already stood
    always_comb begin
        strobe_run_d = strobe_run_q;
        if (strobing) begin
            strobe_run_d = strobe_run_q + 5'h01;
        end else begin
            strobe_run_d = 5'h00;
        end
    end

    // strobe run register, frozen with the clock enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strobe_run_q <= 5'h00;
        end else if (clk_en) begin
            strobe_run_q <= strobe_run_d;
        end
    end

    // ************************************************
    // checks: pins and hold
    // ************************************************
    // pins float while granted, strobes exclusive
    a_grant_floats: assert property (@(posedge sys_clk) disable iff (rst)
        !bus_hold_grant_n |-> !bank_sel_oe && !ext_word_address_oe && !strobe_oe)
        else $error("pins driven while granted");
    a_data_float: assert property (@(posedge sys_clk) disable iff (rst)
        ext_data_bus_oe |-> !ext_write_strobe_n_o && bus_hold_grant_n)
        else $error("data driven outside write");
    a_strobe_excl: assert property (@(posedge sys_clk) disable iff (rst)
        !(!ext_read_strobe_n_o && !ext_write_strobe_n_o))
        else $error("both strobes low");
    a_owned_strobe: assert property (@(posedge sys_clk) disable iff (rst)
        !bus_owned_strobe_n == (!ext_read_strobe_n_o || !ext_write_strobe_n_o))
        else $error("owned strobe mismatch");
    a_grant_excl: assert property (@(posedge sys_clk) disable iff (rst)
        !(!bus_hold_grant_n && !bus_owned_strobe_n))
        else $error("grant during own access");
    a_grant_req: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !bus_hold_request_n && state_q == ext_mem_pkg::ST_IDLE |=> !bus_hold_grant_n)
        else $error("grant not given");
    a_grant_held: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !bus_hold_grant_n && !bus_hold_request_n |=> !bus_hold_grant_n)
        else $error("grant dropped while requested");
    a_grant_release: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !bus_hold_grant_n && bus_hold_request_n |=> bus_hold_grant_n)
        else $error("grant kept after request ended");
    a_grant_unasked: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && bus_hold_grant_n && bus_hold_request_n |=> bus_hold_grant_n)
        else $error("grant without request");
    a_ready_free: assert property (@(posedge sys_clk) disable iff (rst)
        req_ready |-> bus_owned_strobe_n && bus_hold_grant_n)
        else $error("ready while bus busy");
    a_own_drives: assert property (@(posedge sys_clk) disable iff (rst)
        !bus_owned_strobe_n |-> bank_sel_oe && ext_word_address_oe && strobe_oe)
        else $error("pins floating during own access");

    // ************************************************
    // checks: address, bank and clock enable
    // ************************************************
    // address and bank load on take, hold otherwise
    a_addr_hold: assert property (@(posedge sys_clk) disable iff (rst)
        bus_owned_strobe_n && $past(bus_owned_strobe_n) && clk_en && !req_valid
        |=> $stable(ext_word_address_o))
        else $error("address moved while idle");
    a_bank_hold: assert property (@(posedge sys_clk) disable iff (rst)
        bus_owned_strobe_n && clk_en && !req_valid |=> $stable(bank_sel_o))
        else $error("bank moved while idle");
    a_addr_load: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && req_valid && req_ready |=> ext_word_address_o == $past(req_addr)
        && bank_sel_o == $past(req_bank_y))
        else $error("address or bank not loaded");
    a_addr_reset: assert property (@(posedge sys_clk)
        $past(rst) && !rst |-> ext_word_address_o == ext_mem_pkg::ADDR_RESET)
        else $error("address not zero after reset");
    a_reset_pins: assert property (@(posedge sys_clk)
        $past(rst) && !rst |-> ext_read_strobe_n_o && ext_write_strobe_n_o
        && bus_hold_grant_n && !ext_data_bus_oe && bank_sel_o == ext_mem_pkg::BANK_RESET)
        else $error("pins not idle after reset");
    a_enable_freeze: assert property (@(posedge sys_clk) disable iff (rst)
        !clk_en |=> $stable(ext_word_address_o) && $stable(bus_hold_grant_n)
        && $stable(bus_owned_strobe_n) && $stable(rd_valid))
        else $error("state moved with clock enable low");

    // ************************************************
    // checks: strobe and data path
    // ************************************************
    // strobe length, data drive and read capture
    a_strobe_max: assert property (@(posedge sys_clk) disable iff (rst)
        strobing |-> strobe_run_q < 5'(STROBE_LEN))
        else $error("strobe longer than set length");
    a_strobe_end: assert property (@(posedge sys_clk) disable iff (rst)
        !strobing && strobe_run_q != 5'h00 |-> strobe_run_q == 5'(STROBE_LEN))
        else $error("strobe ended early");
    a_take_strobe: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && req_valid && req_ready |=> ext_read_strobe_n_o == $past(req_write)
        && ext_write_strobe_n_o == !$past(req_write))
        else $error("wrong strobe for access");
    a_write_drive: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_write_strobe_n_o |-> ext_data_bus_oe)
        else $error("data not driven in write");
    a_read_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_read_strobe_n_o |-> !ext_data_bus_oe)
        else $error("data driven in read");
    a_idle_float: assert property (@(posedge sys_clk) disable iff (rst)
        bus_owned_strobe_n |-> !ext_data_bus_oe)
        else $error("data driven while idle");
    a_wdata_stable: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_write_strobe_n_o && $past(!ext_write_strobe_n_o) |-> $stable(ext_data_bus_o))
        else $error("write data moved in strobe");
    a_rd_source: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(rd_valid) |-> $past(!ext_read_strobe_n_o))
        else $error("read valid without read strobe");
    a_rdata_capture: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(rd_valid) |-> rd_data == $past(ext_data_bus_i))
        else $error("read data not captured");
    a_rd_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && rd_valid |=> !rd_valid)
        else $error("read valid longer than one cycle");

    // main scenarios reached
    c_read: cover property (@(posedge sys_clk) disable iff (rst)
        !ext_read_strobe_n_o ##[1:8] rd_valid);
    c_write: cover property (@(posedge sys_clk) disable iff (rst) !ext_write_strobe_n_o);
    c_grant: cover property (@(posedge sys_clk) disable iff (rst)
        !bus_hold_grant_n ##[1:20] bus_hold_grant_n);
    c_hold_busy: cover property (@(posedge sys_clk) disable iff (rst)
        !bus_owned_strobe_n && !bus_hold_request_n);
    c_freeze: cover property (@(posedge sys_clk) disable iff (rst) !clk_en && req_valid);
endmodule : ext_data_mem_port

/* ext_mem_model.sv */
`timescale 1ns/1ps
// ****************************************
// external data memory, two banks
// ****************************************
module ext_mem_model (
    // clock
    input wire logic sys_clk,
    // memory pins
    input wire logic bank_sel,
    input wire logic [14:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [15:0] mem [0:65535];
    logic [15:0] last_q = 16'h0000;
    // unwritten words read back as a fixed fill pattern
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'h1234;
        end
    end
    // store a word while the write strobe is low
    always @(posedge sys_clk) begin
        if (wr_n === 1'b0)
            mem[{bank_sel, addr}] <= wdata;
        if (rd_n === 1'b0)
            last_q <= rdata;
    end
    // drive only in read strobe; released lines show a changed value
    always @* begin
        if (rd_n === 1'b0)
            rdata = mem[{bank_sel, addr}];
        else
            rdata = ~last_q;
    end
endmodule : ext_mem_model

/* ext_data_mem_port_with_hold_test.sv */
`timescale 1ns/1ps
module ext_data_mem_port_with_hold_test;
    localparam int SL = 3;
    logic sys_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_bank_y = 1'b0;
    logic [14:0] req_addr = 15'h0000;
    logic [15:0] req_wdata = 16'h0000, rd_data, d_o, d_i, mem_d;
    logic hold_n = 1'b1, req_ready, rd_valid, bank_o, bank_oe, addr_oe, d_oe, rd_n, wr_n, s_oe;
    logic grant_n, owned_n, clk_en = 1'b1;
    logic [14:0] addr_o;
    int err_total = 0, num_checks = 0;
    assign d_i = d_oe ? d_o : mem_d;
    ext_data_mem_port #(.STROBE_LEN(SL)) ext_data_mem_port_i (.sys_clk(sys_clk), .rst(rst),
        .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_bank_y(req_bank_y), .req_addr(req_addr), .req_wdata(req_wdata),
        .rd_valid(rd_valid), .rd_data(rd_data), .bank_sel_o(bank_o), .bank_sel_oe(bank_oe),
        .ext_word_address_o(addr_o), .ext_word_address_oe(addr_oe), .ext_data_bus_i(d_i),
        .ext_data_bus_o(d_o), .ext_data_bus_oe(d_oe), .ext_read_strobe_n_o(rd_n),
        .ext_write_strobe_n_o(wr_n), .strobe_oe(s_oe), .bus_hold_request_n(hold_n),
        .bus_hold_grant_n(grant_n), .bus_owned_strobe_n(owned_n));
    ext_mem_model ext_mem_model_i (.sys_clk(sys_clk), .bank_sel(bank_o), .addr(addr_o),
        .rd_n(rd_n), .wr_n(wr_n), .wdata(d_o), .rdata(mem_d));
    // clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude;
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    // one access, checked at the pins through its strobe
    task automatic access(input logic wr, input logic by, input logic [14:0] a,
                          input logic [15:0] d);
        int n;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_bank_y = by;
        req_addr = a;
        req_wdata = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        chk("ready", 16'h1, {15'h0, req_ready});
        @(negedge sys_clk);
        req_valid = 1'b0;
        chk("bank", {15'h0, by}, {15'h0, bank_o});
        chk("addr", {1'h0, a}, {1'h0, addr_o});
        chk("owned_n", 16'h0, {15'h0, owned_n});
        chk("data_oe", {15'h0, wr}, {15'h0, d_oe});
        chk("idle_strobe", 16'h1, {15'h0, wr ? rd_n : wr_n});
        if (wr)
            chk("wdata", d, d_o);
        n = 0;
        while ((wr ? wr_n : rd_n) === 1'b0 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk("strobe_len", SL[15:0], n[15:0]);
        chk("rd_valid", {15'h0, !wr}, {15'h0, rd_valid});
        if (!wr) begin
            chk("rd_data", d, rd_data);
        end
    endtask : access
    // clock enable low freezes a pending access
    task automatic freeze;
        @(negedge sys_clk);
        clk_en = 1'b0;
        req_valid = 1'b1;
        req_write = 1'b0;
        req_bank_y = 1'b0;
        req_addr = 15'h0002;
        repeat (3) @(negedge sys_clk);
        chk("frozen_addr", 16'h7FFF, {1'h0, addr_o});
        chk("frozen_owned", 16'h1, {15'h0, owned_n});
        clk_en = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        chk("thawed_addr", 16'h0002, {1'h0, addr_o});
        chk("thawed_owned", 16'h0, {15'h0, owned_n});
        repeat (SL + 2) @(negedge sys_clk);
        chk("thawed_rd", 16'h1234, rd_data);
    endtask : freeze
    // hold granted from idle, everything floats, access refused
    task automatic hold_idle;
        @(negedge sys_clk);
        hold_n = 1'b0;
        req_valid = 1'b1;
        @(negedge sys_clk);
        chk("grant_n", 16'h0, {15'h0, grant_n});
        chk("oe", 16'h0, {12'h0, bank_oe, addr_oe, s_oe, d_oe});
        repeat (3) @(negedge sys_clk);
        chk("no_access", 16'h1, {15'h0, owned_n & rd_n});
        req_valid = 1'b0;
        hold_n = 1'b1;
        @(negedge sys_clk);
        chk("release", 16'h7, {13'h0, grant_n, bank_oe, addr_oe});
    endtask : hold_idle
    // hold asked mid-access waits for the access to end
    task automatic hold_busy;
        int n;
        fork
            access(1'b0, 1'b1, 15'h7FFF, 16'h5A3C);
            begin
                repeat (2) @(negedge sys_clk);
                hold_n = 1'b0;
                @(negedge sys_clk);
                chk("grant_wait", 16'h1, {15'h0, grant_n});
            end
        join
        n = 0;
        while (grant_n !== 1'b0 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        chk("grant_late", 16'h1, {15'h0, n <= 3});
        hold_n = 1'b1;
        @(negedge sys_clk);
    endtask : hold_busy
    // watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        chk("reset_addr", 16'h0, {1'h0, addr_o});
        chk("reset_pins", 16'h1C, {11'h0, rd_n, wr_n, grant_n, d_oe, bank_o});
        access(1'b1, 1'b0, 15'h7FFF, 16'hA5C3);
        access(1'b1, 1'b1, 15'h7FFF, 16'h5A3C);
        access(1'b0, 1'b0, 15'h7FFF, 16'hA5C3);
        access(1'b0, 1'b1, 15'h0001, 16'h1234);
        repeat (4) @(negedge sys_clk);
        chk("addr_hold", 16'h1, {1'h0, addr_o});
        chk("idle_float", 16'h0, {15'h0, d_oe});
        hold_idle();
        hold_busy();
        freeze();
        conclude();
    end
endmodule : ext_data_mem_port_with_hold_test
